//--- rtl/lcd_reset_cfg.svh
`ifndef LCD_RESET_CFG_SVH
`define LCD_RESET_CFG_SVH
// =====================================================
// timing figures in their own units, clock rate in kHz
`define CLK_KHZ 40000
`define SPIKE_REJECT_NS 5000
`define SPIKE_ACCEPT_NS 9000
`define RESET_LOW_MIN_WIDTH_NS 10000
`define RELOAD_MAX_US 5000
`define BLANK_MAX_US 120000
`define RESET_RELEASE_SLEEP_US 5000
`define RESET_RELEASE_AWAKE_US 120000
// cycle counts: least times round up; reload and blanking take half their longest time, rounded down
`define SPIKE_ACCEPT_CYC ((`SPIKE_ACCEPT_NS * `CLK_KHZ + 999999) / 1000000)
`define RELOAD_CYC ((`RELOAD_MAX_US * (`CLK_KHZ / 1000)) / 2)
`define BLANK_CYC ((`BLANK_MAX_US * (`CLK_KHZ / 1000)) / 2)
`define RELEASE_AWAKE_CYC (`RESET_RELEASE_AWAKE_US * (`CLK_KHZ / 1000))
// default register value restored after a hardware reset, and the number of words reloaded
`define COMMON_ELECTRODE_DEFAULT 8'h20
`define ID_WORDS 4
`endif

//--- rtl/lcd_reset_pkg.sv
package lcd_reset_pkg;
  // =====================================================
  // sequencer states
  typedef enum logic [2:0] {
    st_run,
    st_blanking,
    st_held,
    st_reload,
    st_settle
  } seq_state_t;

  // configuration word read back from non-volatile storage
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } nv_word_t;

  // loaded configuration presented to the rest of the driver
  typedef struct packed {
    logic [23:0] id_bytes;
    logic [7:0] common_electrode_level;
  } cfg_image_t;
endpackage

//--- rtl/spike_filter.sv
`include "lcd_reset_cfg.svh"
// =====================================================
// spike filter: level must be stable for ACCEPT cycles to change
module spike_filter
  import lcd_reset_pkg::*;
#(
  parameter int ACCEPT = `SPIKE_ACCEPT_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic raw_n,
  output logic clean_n
);
  initial begin
    if (ACCEPT < 2) $error("spike_filter: ACCEPT too small");
  end

  logic sync1;
  logic sync2;
  logic [$clog2(ACCEPT+1)-1:0] stable;

  // two-flop synchroniser for the asynchronous pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= raw_n;
      sync2 <= sync1;
    end
  end

  // a change shorter than ACCEPT restarts the count, in both directions,
  // so spikes inside an asserted reset are rejected too
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stable <= '0;
      clean_n <= 1'b1;
    end else if (sync2 == clean_n) begin
      stable <= '0;
    end else if (stable == ($clog2(ACCEPT+1))'(ACCEPT - 1)) begin
      // the new level has now been seen on ACCEPT edges in a row
      stable <= '0;
      clean_n <= sync2;
    end else begin
      stable <= stable + 1'b1;
    end
  end
endmodule // spike_filter

//--- rtl/lcd_reset_sequencer.sv
`include "lcd_reset_cfg.svh"
module lcd_reset_sequencer
  import lcd_reset_pkg::*;
#(
  parameter int ACCEPT_CYC = `SPIKE_ACCEPT_CYC,
  parameter int RELOAD_CYC = `RELOAD_CYC,
  parameter int BLANK_CYC = `BLANK_CYC,
  parameter int AWAKE_CYC = `RELEASE_AWAKE_CYC,
  parameter int ID_WORDS = `ID_WORDS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hw_reset_n,
  input wire logic awake,
  input wire nv_word_t nv_word,
  input wire logic nv_valid,
  output logic nv_req,
  output logic panel_blank,
  output logic defaults_load,
  output logic ready,
  output cfg_image_t cfg
);
  initial begin
    if (RELOAD_CYC < 1 || BLANK_CYC < 1 || AWAKE_CYC < RELOAD_CYC)
      $error("lcd_reset_sequencer: bad timing parameters");
    if (ID_WORDS < 4) $error("lcd_reset_sequencer: ID_WORDS below 4");
  end

  // =====================================================
  // filtered reset level
  logic reset_clean_n;

  spike_filter #(
    .ACCEPT(ACCEPT_CYC)
  ) u_filter (
    .clk(clk),
    .rst_b(rst_b),
    .raw_n(hw_reset_n),
    .clean_n(reset_clean_n)
  );

  // =====================================================
  // state and timing
  seq_state_t state;
  logic [$clog2(AWAKE_CYC+1)-1:0] timer;
  logic [$clog2(AWAKE_CYC+1)-1:0] settle_limit;
  logic was_awake;
  logic [$clog2(ID_WORDS+1)-1:0] words_seen;
  logic awake_sync1;
  logic awake_sync2;

  // awake comes from the display-state logic on this clock: no sync
  // needed, but a two-flop pipeline keeps its read in step with the two synchroniser flops
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      awake_sync1 <= 1'b0;
      awake_sync2 <= 1'b0;
    end else begin
      awake_sync1 <= awake;
      awake_sync2 <= awake_sync1;
    end
  end

  function automatic logic [$clog2(AWAKE_CYC+1)-1:0] cyc(input int n);
    cyc = ($clog2(AWAKE_CYC+1))'(n);
  endfunction

  // sequencer: entry on filtered low, reload after filtered release
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= st_run;
      timer <= '0;
      was_awake <= 1'b0;
      settle_limit <= '0;
    end else begin
      unique case (state)
        st_run: begin
          timer <= '0;
          if (!reset_clean_n) begin
            was_awake <= awake_sync2;
            state <= awake_sync2 ? st_blanking : st_held;
          end
        end
        st_blanking: begin
          // blanking finishes inside the 120 ms budget, then holds
          timer <= timer + 1'b1;
          if (timer == cyc(BLANK_CYC - 1)) begin
            state <= st_held;
            timer <= '0;
          end
        end
        st_held: begin
          timer <= '0;
          if (reset_clean_n) begin
            state <= st_reload;
          end
        end
        st_reload: begin
          timer <= timer + 1'b1;
          if (!reset_clean_n) begin
            state <= st_held;
            timer <= '0;
          end else if (words_seen == ($clog2(ID_WORDS+1))'(ID_WORDS)
              || timer == cyc(RELOAD_CYC - 1)) begin
            // storage that stalls is cut off so the reload deadline holds
            state <= st_settle;
            settle_limit <= was_awake ? cyc(AWAKE_CYC - 1)
                : cyc(RELOAD_CYC - 1);
          end
        end
        st_settle: begin
          timer <= timer + 1'b1;
          if (!reset_clean_n) begin
            state <= st_held;
            timer <= '0;
          end else if (timer >= settle_limit) begin
            state <= st_run;
          end
        end
        default: state <= st_run;
      endcase
    end
  end

  // =====================================================
  // configuration reload from non-volatile storage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      words_seen <= '0;
      nv_req <= 1'b0;
      cfg <= '{id_bytes: 24'h00_0000,
               common_electrode_level: `COMMON_ELECTRODE_DEFAULT};
    end else if (state == st_held) begin
      words_seen <= '0;
      nv_req <= 1'b0;
      // defaults apply first; storage then overwrites them
      cfg <= '{id_bytes: 24'h00_0000,
               common_electrode_level: `COMMON_ELECTRODE_DEFAULT};
    end else if (state == st_reload) begin
      nv_req <= (words_seen != ($clog2(ID_WORDS+1))'(ID_WORDS));
      if (nv_valid && nv_req) begin
        words_seen <= words_seen + 1'b1;
        unique case (nv_word.addr)
          8'h00: cfg.id_bytes[23:16] <= nv_word.data;
          8'h01: cfg.id_bytes[15:8] <= nv_word.data;
          8'h02: cfg.id_bytes[7:0] <= nv_word.data;
          8'h03: cfg.common_electrode_level <= nv_word.data;
          default: ; // unknown addresses are other settings, skipped
        endcase
      end
    end else begin
      nv_req <= 1'b0;
    end
  end

  // =====================================================
  // outputs to panel and command decoder, all registered
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      panel_blank <= 1'b1;
      defaults_load <= 1'b1;
      ready <= 1'b0;
    end else begin
      panel_blank <= (state != st_run);
      defaults_load <= (state == st_held);
      ready <= (state == st_run) && reset_clean_n;
    end
  end
endmodule // lcd_reset_sequencer

//--- testbench/lcd_reset_checker.sv
// =====================================================
// reset sequencer checker
module lcd_reset_checker
  import lcd_reset_pkg::*;
#(
  parameter int ACCEPT_CYC = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hw_reset_n,
  input wire logic awake,
  input wire nv_word_t nv_word,
  input wire logic nv_valid,
  input wire logic nv_req,
  input wire logic panel_blank,
  input wire logic defaults_load,
  input wire logic ready,
  input wire cfg_image_t cfg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [4:0] lo;
  logic [4:0] hi;
  // pin run lengths, saturating so a long hold never wraps
  always_ff @(posedge clk) begin
    lo <= (!rst_b || hw_reset_n) ? 5'h00 : lo + {4'h0, lo != 5'h1F};
    hi <= (!rst_b || !hw_reset_n) ? 5'h00 : hi + {4'h0, hi != 5'h1F};
  end
  // held to reload, not the first exit from rst_b
  sequence s_rel;
    $fell(defaults_load) && $past(rst_b, 2);
  endsequence
  a_spike_rejected: assert property ($rose(panel_blank) |-> lo >= ACCEPT_CYC)
    else $error("reset taken from short low");
  a_release_filtered: assert property (s_rel |-> hi >= ACCEPT_CYC)
    else $error("release taken from short high");
  a_reload_starts: assert property (s_rel |-> ##[0:2] nv_req)
    else $error("no reload after release");
  a_reload_bounded: assert property ($rose(nv_req) |-> ##[1:21] !nv_req)
    else $error("reload too long");
  a_done_in_time: assert property (s_rel |-> ##[1:110] ready)
    else $error("sequence not done in time");
  a_awake_blanking: assert property ($rose(panel_blank) && awake |->
    !defaults_load ##[1:40] defaults_load)
    else $error("blanking length wrong");
  a_held_blank: assert property (defaults_load |-> panel_blank)
    else $error("panel shown while held");
  a_sleep_direct: assert property ($rose(panel_blank) && !awake |->
    ##[0:3] defaults_load)
    else $error("sleep reset not held");
  a_ready_clear: assert property (ready |-> !panel_blank && !defaults_load)
    else $error("ready while resetting");
  a_default_image: assert property (defaults_load ##1 defaults_load |->
    cfg == {24'h000000, 8'h20})
    else $error("defaults not applied");
  c_awake: cover property ($rose(panel_blank) && awake);
  c_reload: cover property ($rose(nv_req));
  c_ready: cover property ($rose(ready));
endmodule // lcd_reset_checker

bind lcd_reset_sequencer lcd_reset_checker #(.ACCEPT_CYC(ACCEPT_CYC))
  lcd_reset_checker_i (.clk(clk), .rst_b(rst_b), .hw_reset_n(hw_reset_n),
  .awake(awake), .nv_word(nv_word), .nv_valid(nv_valid), .nv_req(nv_req),
  .panel_blank(panel_blank), .defaults_load(defaults_load),
  .ready(ready), .cfg(cfg));

//--- testbench/nv_store_model.sv
// =====================================================
// storage model: data of word n is A0 plus n
module nv_store_model
  import lcd_reset_pkg::*;
(
  input wire logic clk,
  input wire logic nv_req,
  input wire logic slow,
  output nv_word_t nv_word,
  output logic nv_valid
);
  logic [7:0] addr = 8'h00;
  logic [1:0] gap = 2'h0;
  initial nv_word = 16'h5A5A;
  initial nv_valid = 1'b0;
  // idle bus toggles so no stale word looks like data
  always @(posedge clk) begin
    nv_valid <= nv_req && gap == 2'h0;
    nv_word <= ~nv_word;
    if (!nv_req) begin
      addr <= 8'h00;
      gap <= 2'h0;
    end else if (gap == 2'h0) begin
      nv_word <= {addr, 4'hA, addr[3:0]};
      addr <= addr + 8'h01;
      gap <= slow ? 2'h3 : 2'h0;
    end else begin
      gap <= gap - 2'h1;
    end
  end
endmodule // nv_store_model

//--- testbench/lcd_reset_sequencer_bench.sv
// =====================================================
// reset sequencer bench
module lcd_reset_sequencer_bench
  import lcd_reset_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] IMG = 32'hA0A1A2A3;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hw_reset_n = 1'b1;
  logic awake = 1'b0;
  logic slow = 1'b0;
  nv_word_t nv_word;
  logic nv_valid, nv_req, panel_blank, defaults_load, ready;
  cfg_image_t cfg;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  lcd_reset_sequencer #(.ACCEPT_CYC(4), .RELOAD_CYC(20), .BLANK_CYC(30),
    .AWAKE_CYC(100), .ID_WORDS(4)) lcd_reset_sequencer_i (.clk(clk),
    .rst_b(rst_b), .hw_reset_n(hw_reset_n), .awake(awake), .nv_word(nv_word),
    .nv_valid(nv_valid), .nv_req(nv_req), .panel_blank(panel_blank),
    .defaults_load(defaults_load), .ready(ready), .cfg(cfg));
  nv_store_model nv_store_model_i (.clk(clk), .nv_req(nv_req), .slow(slow),
    .nv_word(nv_word), .nv_valid(nv_valid));
  always #12.5 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // cut a hang: all tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    n = 0;
    while (ready !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic pin(input logic v, input int len);
    hw_reset_n <= v;
    repeat (len) @(posedge clk);
  endtask
  // host keeps well clear of commands until ready, so hold
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    wait_ready();
    check(cfg, 32'h20);
    check(panel_blank, 0);
    pin(0, 3);
    pin(1, 12);
    check(panel_blank, 0);
    check(ready, 1);
    $display("spike test done");
    pin(0, 10);
    pin(1, 1);
    pin(0, 10);
    check(defaults_load, 1);
    check(panel_blank, 1);
    pin(1, 0);
    wait_ready();
    check(cfg, IMG);
    check(n >= 19 && n <= 36, 1);
    $display("sleep test done");
    awake <= 1'b1;
    slow <= 1'b1;
    pin(0, 12);
    check(panel_blank, 1);
    check(defaults_load, 0);
    pin(0, 40);
    check(defaults_load, 1);
    pin(1, 0);
    wait_ready();
    check(n >= 99 && n <= 116, 1);
    check(cfg, IMG);
    $display("awake test done");
    complete_run();
  end
endmodule // lcd_reset_sequencer_bench
